// *** rtl/data_pointer_bank.sv ***
// Two data pointers, one selected for every pointer operation
`timescale 1ns/1ps
`default_nettype none
`include "serial_route_map.svh"
module data_pointer_bank
    import serial_route_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // Pointer operation
    input  wire logic             bank_sel,
    input  var  ptr_op_e          op,
    input  wire logic [WIDTH-1:0] load_value,
    output logic      [WIDTH-1:0] ptr_value
);
    logic [WIDTH-1:0] pointer [2];

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_ptr
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    pointer[i] <= WIDTH'(`DATA_PTR_RESET);
                end else if (bank_sel == 1'(i)) begin
                    case (op)
                        ptr_load: pointer[i] <= load_value;
                        ptr_incr: pointer[i] <= pointer[i] + WIDTH'(1);
                        default:  pointer[i] <= pointer[i];
                    endcase
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_value <= WIDTH'(`DATA_PTR_RESET);
        end else begin
            ptr_value <= bank_sel ? pointer[1] : pointer[0];
        end
    end
endmodule
`default_nettype wire

// *** rtl/serial_pin_route_data_pointer_reg_select.sv ***
// Auxiliary register: serial pin routing, software flag, data pointer bank select
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "serial_route_map.svh"
module serial_pin_route_data_pointer_reg_select
    import serial_route_pkg::*;
#(
    parameter int PTR_WIDTH = 16
) (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    // Register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // Serial engine side
    input  wire logic                 uart_txd,
    output logic                      uart_rxd,
    // Port pins
    input  wire logic                 p30_in,
    input  wire logic                 p16_in,
    output logic                      p31_out,
    output logic                      p31_oe,
    output logic                      p17_out,
    output logic                      p17_oe,
    // Data pointer operations
    input  var  ptr_op_e              ptr_op,
    input  wire logic [PTR_WIDTH-1:0] ptr_load_value,
    output logic      [PTR_WIDTH-1:0] ptr_value,
    output logic                      ptr_bank
);
    reg_req_s  req;
    aux_ctrl_s ctrl;
    logic      p30_meta, p30_sync, p16_meta, p16_sync;
    logic      hit_wr, hit_rd;

    // Register address decode
    function automatic logic is_aux_addr(input logic [7:0] addr);
        return addr == `AUX_CTRL_ADDR;
    endfunction

    assign req    = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign hit_wr = req.wr && is_aux_addr(req.addr);
    assign hit_rd = req.rd && is_aux_addr(req.addr);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= '{default: 1'b0};
        end else if (hit_wr) begin
            ctrl.route_sel <= req.wdata[`ROUTE_SEL_BIT];
            ctrl.gp_flag   <= req.wdata[`GP_FLAG_BIT];
            ctrl.bank_sel  <= req.wdata[`PTR_BANK_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= `AUX_CTRL_RESET;
        end else if (hit_rd) begin
            reg_rdata <= {ctrl.route_sel, 3'h0, ctrl.gp_flag, 2'h0, ctrl.bank_sel}
                         & `AUX_CTRL_WMASK;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Pin input synchronisers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            p30_meta <= 1'b1;
            p30_sync <= 1'b1;
            p16_meta <= 1'b1;
            p16_sync <= 1'b1;
        end else begin
            p30_meta <= p30_in;
            p30_sync <= p30_meta;
            p16_meta <= p16_in;
            p16_sync <= p16_meta;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            uart_rxd <= 1'b1;
            p31_out  <= 1'b1;
            p31_oe   <= 1'b0;
            p17_out  <= 1'b1;
            p17_oe   <= 1'b0;
        end else begin
            uart_rxd <= ctrl.route_sel ? p16_sync : p30_sync;
            p31_out  <= uart_txd;
            p31_oe   <= !ctrl.route_sel;
            p17_out  <= uart_txd;
            p17_oe   <= ctrl.route_sel;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_bank <= 1'b0;
        end else begin
            ptr_bank <= ctrl.bank_sel;
        end
    end

    data_pointer_bank #(
        .WIDTH (PTR_WIDTH)
    ) u_ptr (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .bank_sel   (ctrl.bank_sel),
        .op         (ptr_op),
        .load_value (ptr_load_value),
        .ptr_value  (ptr_value)
    );

    // Checks
    // port 3 routing
    a_route_p3: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (hit_wr && !req.wdata[`ROUTE_SEL_BIT]) |=> ##1 (p31_oe && !p17_oe))
        else $error("route 0 not on port 3");

    a_route_p1: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (hit_wr && req.wdata[`ROUTE_SEL_BIT]) |=> ##1 (p17_oe && !p31_oe))
        else $error("route 1 not on port 1");

    a_flag_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (hit_wr ##1 (req.rd && req.addr == `AUX_CTRL_ADDR && !req.wr))
        |=> reg_rdata[`GP_FLAG_BIT] == $past(req.wdata[`GP_FLAG_BIT], 2))
        else $error("flag read back wrong");

    a_bank_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!ctrl.bank_sel && ptr_op == ptr_load) |=> ##1 ptr_value == $past(ptr_load_value, 2))
        else $error("primary pointer not used");

    a_bank_one: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (hit_wr && req.wdata[`PTR_BANK_BIT]) |=> ##1 ptr_bank)
        else $error("bank 1 not selected");

    a_reset_clear: assert property (@(posedge sys_clk)
        $rose(reset_n) |-> (ctrl == '0 && !ptr_bank))
        else $error("reset value wrong");

    a_unimpl_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (reg_rdata & ~`AUX_CTRL_WMASK) == 8'h00)
        else $error("unimplemented bits not zero");

    a_rx_route: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (ctrl.route_sel && $stable(ctrl.route_sel)) |=> uart_rxd == $past(p16_sync))
        else $error("receive not from port 1");

    a_rx_p3: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!ctrl.route_sel && $stable(ctrl.route_sel)) |=> uart_rxd == $past(p30_sync))
        else $error("receive not from port 3");

    a_oe_onehot: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $past(reset_n) |-> (p31_oe != p17_oe))
        else $error("pin enables not exclusive");

    a_tx_p31: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $past(reset_n) |-> p31_out == $past(uart_txd))
        else $error("port 3 transmit wrong");

    a_tx_p17: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $past(reset_n) |-> p17_out == $past(uart_txd))
        else $error("port 1 transmit wrong");

    a_flag_inert: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ($changed(ctrl.gp_flag) && $stable(ctrl.route_sel) && $stable(ctrl.bank_sel))
        |=> ($stable(p31_oe) && $stable(ptr_bank)))
        else $error("flag changed other outputs");

    a_rdata_value: assert property (@(posedge sys_clk) disable iff (!reset_n)
        hit_rd |=> (reg_rdata[`ROUTE_SEL_BIT] == $past(ctrl.route_sel)
            && reg_rdata[`GP_FLAG_BIT] == $past(ctrl.gp_flag)
            && reg_rdata[`PTR_BANK_BIT] == $past(ctrl.bank_sel)))
        else $error("read data fields wrong");

    a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !$past(hit_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");

    a_bank_out: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $past(reset_n) |-> ptr_bank == $past(ctrl.bank_sel))
        else $error("bank output wrong");

    a_bank_load_one: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (ctrl.bank_sel && ptr_op == ptr_load) |=> ##1 ptr_value == $past(ptr_load_value, 2))
        else $error("secondary pointer not used");
endmodule
`default_nettype wire

// *** rtl/serial_route_map.svh ***
// Register offsets, field positions and reset values of the auxiliary control register
`ifndef SERIAL_ROUTE_MAP_SVH
`define SERIAL_ROUTE_MAP_SVH
`define AUX_CTRL_ADDR     8'ha2
`define ROUTE_SEL_BIT     7
`define GP_FLAG_BIT       3
`define PTR_BANK_BIT      0
`define AUX_CTRL_RESET    8'h00
`define AUX_CTRL_WMASK    8'h89
`define DATA_PTR_RESET    16'h0000
`endif

// *** rtl/serial_route_pkg.sv ***
// Types shared by the serial pin route block
package serial_route_pkg;
    typedef struct packed {
        logic route_sel;
        logic gp_flag;
        logic bank_sel;
    } aux_ctrl_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef enum logic [1:0] {
        ptr_nop   = 2'b00,
        ptr_load  = 2'b01,
        ptr_incr  = 2'b10
    } ptr_op_e;
endpackage

// *** tb/test_serial_pin_route_data_pointer_reg_select.sv ***
// Self-checking bench for the serial pin route and pointer select register
`timescale 1ns/1ps
`default_nettype none
`include "serial_route_map.svh"
module test_serial_pin_route_data_pointer_reg_select
    import serial_route_pkg::*;
;
    logic        sys_clk, reset_n, reg_wr, reg_rd, uart_txd, p30_in, p16_in;
    logic  [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic        uart_rxd, p31_out, p31_oe, p17_out, p17_oe, ptr_bank;
    ptr_op_e     ptr_op;
    logic [15:0] ptr_load_value, ptr_value;
    int          num_errors, checked;
    // Written value beside expected readback
    logic  [7:0] rows [0:6][0:1] = '{'{8'h00, 8'h00}, '{8'h81, 8'h81}, '{8'h08, 8'h08},
        '{8'h76, 8'h00}, '{8'hff, 8'h89}, '{8'h80, 8'h80}, '{8'h01, 8'h01}};

    serial_pin_route_data_pointer_reg_select u_serial_pin_route_data_pointer_reg_select (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .uart_txd(uart_txd),
        .uart_rxd(uart_rxd), .p30_in(p30_in), .p16_in(p16_in), .p31_out(p31_out),
        .p31_oe(p31_oe), .p17_out(p17_out), .p17_oe(p17_oe), .ptr_op(ptr_op),
        .ptr_load_value(ptr_load_value), .ptr_value(ptr_value), .ptr_bank(ptr_bank));

    always #20 sys_clk = ~sys_clk;

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask

    task wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask

    task op(input ptr_op_e o, input logic [15:0] v);
        @(posedge sys_clk);
        ptr_op <= o;
        ptr_load_value <= v;
        @(posedge sys_clk);
        ptr_op <= ptr_nop;
    endtask

    task settle;
        repeat (5) @(posedge sys_clk);
        #1;
    endtask

    task summarize;
        if (num_errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge sys_clk);
        num_errors++;
        summarize();
    end

    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        {reg_wr, reg_rd, uart_txd, p30_in, p16_in} = 5'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        ptr_op = ptr_nop;
        ptr_load_value = 16'h0000;
        num_errors = 0;
        checked = 0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        settle();
        chk({p31_oe, p17_oe, ptr_bank}, 3'b100);
        chk(ptr_value, 16'h0000);
        rd(`AUX_CTRL_ADDR);
        chk(rv, `AUX_CTRL_RESET);
        for (int i = 0; i < 7; i++) begin
            @(posedge sys_clk);
            p30_in <= i[0];
            p16_in <= ~i[0];
            uart_txd <= ~i[0];
            wr_rd(`AUX_CTRL_ADDR, rows[i][0]);
            chk(rv, rows[i][1]);
            settle();
            chk(reg_rdata, 8'h00);
            chk({p31_oe, p17_oe, ptr_bank}, {~rows[i][1][7], rows[i][1][7], rows[i][1][0]});
            chk(uart_rxd, 1'(rows[i][1][7] ? ~i[0] : i[0]));
            chk({p31_out, p17_out}, {2{~i[0]}});
        end
        wr(8'ha3, 8'h88);
        rd(8'ha3);
        chk(rv, 8'h00);
        rd(`AUX_CTRL_ADDR);
        chk(rv, 8'h01);
        op(ptr_load, 16'habcd);
        settle();
        chk(ptr_value, 16'habcd);
        wr(`AUX_CTRL_ADDR, 8'h00);
        settle();
        chk(ptr_value, 16'h0000);
        op(ptr_load, 16'h1234);
        op(ptr_incr, 16'h0000);
        op(ptr_incr, 16'h0000);
        settle();
        chk(ptr_value, 16'h1236);
        wr(`AUX_CTRL_ADDR, 8'h89);
        settle();
        chk(ptr_value, 16'habcd);
        chk({p31_oe, p17_oe}, 2'h1);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        #1;
        chk({p31_oe, p17_oe, ptr_bank}, 3'b000);
        chk(ptr_value, 16'h0000);
        chk(uart_rxd, 1'h1);
        @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(`AUX_CTRL_ADDR);
        chk(rv, 8'h00);
        settle();
        chk({p31_oe, p17_oe, ptr_bank}, 3'h4);
        summarize();
    end
endmodule
`default_nettype wire
